//--- core/fifo_flag_pkg.sv
// Constants and carrier types shared by the flag-programmable FIFO
package fifo_flag_pkg;

  localparam int DATA_W = 9;
  localparam int OFFSET_BYTE_W = 8;
  localparam int OFFSET_W = 16;
  localparam int OFFSET_REGS = 4;
  localparam int FIFO_DEPTH = 64;
  localparam logic [7:0] OFFSET_LO_RESET = 8'h07;
  localparam logic [7:0] OFFSET_HI_RESET = 8'h00;
  localparam logic [1:0] SEL_FIRST = 2'h0;
  localparam logic [1:0] SEL_STEP = 2'h1;

  // APB map
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_OFFSETS = 8'h04;
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_AEMPTY_BIT = 2;
  localparam int ST_AFULL_BIT = 3;
  localparam int ST_LOAD_MODE_BIT = 4;
  localparam int ST_SEL_LSB = 8;
  localparam int ST_COUNT_LSB = 16;
  localparam int OFS_EMPTY_LSB = 0;
  localparam int OFS_FULL_LSB = 16;

  typedef struct packed {
    logic master_reset_n;
    logic wr_clk;
    logic rd_clk;
    logic wr_en_primary_n;
    logic wr_en_second_or_load;
    logic rd_en_primary_n;
    logic rd_en_second_n;
    logic [DATA_W-1:0] data;
  } pin_bus_s;

  typedef struct packed {
    logic empty_n;
    logic full_n;
    logic almost_empty_n;
    logic almost_full_n;
  } flags_s;

  localparam flags_s FLAGS_RESET = '{
    empty_n: 1'b0, full_n: 1'b1, almost_empty_n: 1'b0, almost_full_n: 1'b1
  };

endpackage

//--- core/fifo_store.sv
// Dual-port storage array with registered read data
`timescale 1ns/100ps
module fifo_store #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 64,
  parameter int ADDR_W = 6
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Array itself has no reset: contents are undefined until written
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule

//--- core/pin_sync.sv
// Two-stage synchroniser for a group of pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

//--- core/sync_fifo_flags.sv
// Synchronous FIFO with empty, full and programmable almost flags, APB status port
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module sync_fifo_flags #(
  parameter int DEPTH = fifo_flag_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic master_reset_n,
  input wire logic wr_clk,
  input wire logic rd_clk,
  input wire logic wr_en_primary_n,
  input wire logic wr_en_second_or_load,
  input wire logic rd_en_primary_n,
  input wire logic rd_en_second_n,
  input wire logic [fifo_flag_pkg::DATA_W-1:0] data_in,
  output logic [fifo_flag_pkg::DATA_W-1:0] data_out,
  output logic empty_n,
  output logic full_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fifo_flag_pkg::APB_AW-1:0] paddr,
  input wire logic [fifo_flag_pkg::APB_DW-1:0] pwdata,
  output logic [fifo_flag_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W = ADDR_W + 1;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam int PIN_W = $bits(fifo_flag_pkg::pin_bus_s);

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  fifo_flag_pkg::pin_bus_s pins_raw;
  fifo_flag_pkg::pin_bus_s pins_s;
  logic wr_clk_d_q;
  logic rd_clk_d_q;

  assign pins_raw = {master_reset_n, wr_clk, rd_clk, wr_en_primary_n,
                     wr_en_second_or_load, rd_en_primary_n, rd_en_second_n, data_in};

  // Both link clocks are sampled by sys_clk, so every pointer lives in one domain
  pin_sync #(.WIDTH(PIN_W)) u_pin_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_clk_d_q <= 1'b0;
      rd_clk_d_q <= 1'b0;
    end else begin
      wr_clk_d_q <= pins_s.wr_clk;
      rd_clk_d_q <= pins_s.rd_clk;
    end
  end

  wire wr_rise = pins_s.wr_clk & ~wr_clk_d_q;
  wire rd_rise = pins_s.rd_clk & ~rd_clk_d_q;
  wire mrst_act = ~pins_s.master_reset_n;

  // ----------------------------------------------------------------
  // Mode strap and request decode
  // ----------------------------------------------------------------
  logic load_mode_q;

  // Pin level tracked for as long as master reset is held; last value sticks
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      load_mode_q <= 1'b0;
    end else if (mrst_act) begin
      load_mode_q <= ~pins_s.wr_en_second_or_load;
    end
  end

  fifo_flag_pkg::flags_s flags_q;

  wire ld_active = load_mode_q & ~pins_s.wr_en_second_or_load;
  wire rd_en_both = ~pins_s.rd_en_primary_n & ~pins_s.rd_en_second_n;
  wire run = ~mrst_act;
  // Same term serves both modes: pin high is either enable or load released
  wire wr_req = wr_rise & run & ~pins_s.wr_en_primary_n & pins_s.wr_en_second_or_load;
  wire wr_fire = wr_req & flags_q.full_n;
  wire rd_fire = rd_rise & run & ~ld_active & rd_en_both & flags_q.empty_n;
  wire ofs_wr = wr_rise & run & ld_active & ~pins_s.wr_en_primary_n;
  wire ofs_rd = rd_rise & run & ld_active & rd_en_both;

  // ----------------------------------------------------------------
  // Offset registers
  // ----------------------------------------------------------------
  logic [fifo_flag_pkg::OFFSET_BYTE_W-1:0] ofs_q [fifo_flag_pkg::OFFSET_REGS];
  logic [1:0] sel_q;
  logic apb_ofs_wr;

  // Selection is only cleared by reset_n or master reset, never by releasing load
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= fifo_flag_pkg::SEL_FIRST;
    end else if (mrst_act) begin
      sel_q <= fifo_flag_pkg::SEL_FIRST;
    end else if (ofs_wr || ofs_rd) begin
      // Simultaneous offset write and read advance once only
      sel_q <= sel_q + fifo_flag_pkg::SEL_STEP;
    end
  end

  for (genvar i = 0; i < fifo_flag_pkg::OFFSET_REGS; i++) begin : g_ofs
    localparam logic [7:0] RST_VAL = (i % 2 == 0) ? fifo_flag_pkg::OFFSET_LO_RESET
                                                   : fifo_flag_pkg::OFFSET_HI_RESET;
    localparam logic [1:0] IDX = 2'(i);
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        ofs_q[i] <= RST_VAL;
      end else if (mrst_act) begin
        ofs_q[i] <= RST_VAL;
      end else if (apb_ofs_wr) begin
        ofs_q[i] <= pwdata[i*8 +: 8];
      end else if (ofs_wr && sel_q == IDX) begin
        ofs_q[i] <= pins_s.data[7:0];
      end
    end
  end

  wire [fifo_flag_pkg::OFFSET_W-1:0] n_val = {ofs_q[1], ofs_q[0]};
  wire [fifo_flag_pkg::OFFSET_W-1:0] m_val = {ofs_q[3], ofs_q[2]};

  // ----------------------------------------------------------------
  // Pointers, storage and count
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] wr_ptr_q;
  logic [CNT_W-1:0] rd_ptr_q;
  logic rd_fire_d_q;
  logic [fifo_flag_pkg::DATA_W-1:0] mem_rd_data;

  // Depth must be a power of two so the extra pointer bit wraps cleanly
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      rd_fire_d_q <= 1'b0;
    end else if (mrst_act) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      rd_fire_d_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + CNT_W'(wr_fire);
      rd_ptr_q <= rd_ptr_q + CNT_W'(rd_fire);
      rd_fire_d_q <= rd_fire;
    end
  end

  fifo_store #(
    .WIDTH(fifo_flag_pkg::DATA_W),
    .DEPTH(DEPTH),
    .ADDR_W(ADDR_W)
  ) u_store (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(wr_fire),
    .wr_addr(wr_ptr_q[ADDR_W-1:0]),
    .wr_data(pins_s.data),
    .rd_en(rd_fire),
    .rd_addr(rd_ptr_q[ADDR_W-1:0]),
    .rd_data_q(mem_rd_data)
  );

  wire [CNT_W-1:0] count = wr_ptr_q - rd_ptr_q;
  wire [CNT_W-1:0] cnt_after = count + CNT_W'(wr_fire) - CNT_W'(rd_fire);
  wire [CNT_W-1:0] free_after = DEPTH_C - cnt_after;
  wire [fifo_flag_pkg::OFFSET_W-1:0] cnt_ext = fifo_flag_pkg::OFFSET_W'(cnt_after);
  wire [fifo_flag_pkg::OFFSET_W-1:0] free_ext = fifo_flag_pkg::OFFSET_W'(free_after);
  wire above_n = cnt_ext > n_val;
  wire free_above_m = free_ext > m_val;
  wire not_empty_next = cnt_after != '0;
  wire not_full_next = cnt_after != DEPTH_C;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= fifo_flag_pkg::FLAGS_RESET;
    end else if (mrst_act) begin
      flags_q <= fifo_flag_pkg::FLAGS_RESET;
    end else begin
      if (rd_rise) begin
        flags_q.empty_n <= not_empty_next;
        flags_q.almost_empty_n <= above_n;
      end
      if (wr_rise) begin
        flags_q.full_n <= not_full_next;
        flags_q.almost_full_n <= free_above_m;
      end
    end
  end

  assign empty_n = flags_q.empty_n;
  assign full_n = flags_q.full_n;
  assign almost_empty_n = flags_q.almost_empty_n;
  assign almost_full_n = flags_q.almost_full_n;

  // ----------------------------------------------------------------
  // Data output register
  // ----------------------------------------------------------------
  wire [fifo_flag_pkg::DATA_W-1:0] ofs_sel_data = {1'b0, ofs_q[sel_q]};

  // Empty FIFO keeps the last word; refused reads leave it untouched
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= '0;
    end else if (mrst_act) begin
      data_out <= '0;
    end else if (ofs_rd) begin
      data_out <= ofs_sel_data;
    end else if (rd_fire_d_q) begin
      data_out <= mem_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [fifo_flag_pkg::APB_DW-1:0] status_word;

  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable & pready;
  wire hit_status = paddr == fifo_flag_pkg::REG_STATUS;
  wire hit_ofs = paddr == fifo_flag_pkg::REG_OFFSETS;
  wire apb_err = ~hit_ofs & ~(hit_status & ~pwrite);
  wire [fifo_flag_pkg::APB_DW-1:0] ofs_word = {m_val, n_val};
  wire [fifo_flag_pkg::APB_DW-1:0] rd_word = pwrite ? '0 : hit_status ? status_word :
                                             hit_ofs ? ofs_word : '0;
  assign apb_ofs_wr = apb_access & pwrite & hit_ofs;

  always_comb begin
    status_word = '0;
    status_word[fifo_flag_pkg::ST_EMPTY_BIT] = flags_q.empty_n;
    status_word[fifo_flag_pkg::ST_FULL_BIT] = flags_q.full_n;
    status_word[fifo_flag_pkg::ST_AEMPTY_BIT] = flags_q.almost_empty_n;
    status_word[fifo_flag_pkg::ST_AFULL_BIT] = flags_q.almost_full_n;
    status_word[fifo_flag_pkg::ST_LOAD_MODE_BIT] = load_mode_q;
    status_word[fifo_flag_pkg::ST_SEL_LSB +: 2] = sel_q;
    status_word[fifo_flag_pkg::ST_COUNT_LSB +: CNT_W] = count;
  end

  // Fixed one-cycle access phase; read data is a snapshot taken at setup
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & apb_err;
      if (apb_setup) begin
        prdata <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_offset_step_order: assert property (
    ofs_wr |=> sel_q == $past(sel_q) + 2'h1
  ) else $error("offset selection did not advance on offset write");

  a_offset_write_data: assert property (
    ofs_wr && !apb_ofs_wr && sel_q == 2'h2 |=> ofs_q[2] == $past(pins_s.data[7:0])
  ) else $error("full offset low byte not loaded from data pins");

  a_offset_read_out: assert property (
    ofs_rd |=> data_out == {1'b0, $past(ofs_q[sel_q])} && sel_q == $past(sel_q) + 2'h1
  ) else $error("offset read did not present selected byte");

  a_aempty_low: assert property (
    rd_rise && run && !above_n |=> !almost_empty_n
  ) else $error("almost empty not low at or below n words");

  a_aempty_high: assert property (
    rd_rise && run && 17'(cnt_ext) >= 17'(n_val) + 17'h00001 |=> almost_empty_n
  ) else $error("almost empty not high at n plus one words");

  a_afull_low: assert property (
    wr_rise && run && 17'(cnt_ext) + 17'(m_val) >= 17'(DEPTH) |=> !almost_full_n
  ) else $error("almost full not low at depth minus m words");

  a_afull_high: assert property (
    wr_rise && run && free_ext > m_val |=> almost_full_n
  ) else $error("almost full not high with more than m free");

  a_offset_default: assert property (
    mrst_act |=> n_val == 16'h0007 && m_val == 16'h0007 && sel_q == 2'h0
  ) else $error("offsets not seven after master reset");

  a_no_write_full: assert property (
    run && !full_n |-> !wr_fire ##1 wr_ptr_q == $past(wr_ptr_q)
  ) else $error("write accepted while full");

  a_full_stable: assert property (
    !wr_rise && run |=> $stable(full_n) && $stable(almost_full_n)
  ) else $error("full flags moved without write clock edge");

  a_no_read_empty: assert property (
    run && !empty_n |-> !rd_fire ##1 rd_ptr_q == $past(rd_ptr_q)
  ) else $error("read performed while empty");

  a_empty_stable: assert property (
    !rd_rise && run |=> $stable(empty_n) && $stable(almost_empty_n)
  ) else $error("empty flags moved without read clock edge");

  a_mode_strap: assert property (
    mrst_act |=> load_mode_q == !$past(pins_s.wr_en_second_or_load)
  ) else $error("mode not taken from dual pin during reset");

  a_count_bound: assert property (
    count <= DEPTH_C && !(count == DEPTH_C && wr_fire)
  ) else $error("unread count exceeds depth");

endmodule

//--- dv/fifo_pin_partner.sv
// Pin-level writer and reader model facing the FIFO
`timescale 1ns/100ps
module fifo_pin_partner (
  input wire logic sys_clk,
  output fifo_flag_pkg::pin_bus_s pins
);
  initial begin
    pins = '0;
    pins.wr_en_primary_n = 1'b1;
    pins.rd_en_primary_n = 1'b1;
    pins.rd_en_second_n = 1'b1;
  end

  // Link clock pulses per transfer at an 80 ns period; controls held 20 ns before each rise
  task automatic pulse(input logic is_wr);
    repeat (2) @(posedge sys_clk);
    if (is_wr) pins.wr_clk <= 1'b1;
    else pins.rd_clk <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pins.wr_clk <= 1'b0;
    pins.rd_clk <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic dev_reset(input logic ld);
    pins.master_reset_n <= 1'b0;
    pins.wr_en_second_or_load <= ld;
    pins.wr_en_primary_n <= 1'b1;
    pins.rd_en_primary_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    pins.master_reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  // Writes and reads never share a period
  task automatic wr_cycle(input logic en_n, input logic ld, input logic [8:0] d);
    pins.rd_en_primary_n <= 1'b1;
    pins.wr_en_primary_n <= en_n;
    pins.wr_en_second_or_load <= ld;
    pins.data <= d;
    pulse(1'b1);
  endtask

  // Data lines no longer hold the last word once reading
  task automatic rd_cycle(input logic p_n, input logic s_n, input logic ld);
    pins.wr_en_primary_n <= 1'b1;
    pins.rd_en_primary_n <= p_n;
    pins.rd_en_second_n <= s_n;
    pins.wr_en_second_or_load <= ld;
    pins.data <= ~pins.data;
    pulse(1'b0);
  endtask
endmodule

//--- dv/sync_fifo_programmable_flags_tb.sv
// Self-checking bench for the flag-programmable FIFO
`timescale 1ns/100ps
module sync_fifo_programmable_flags_tb;
  localparam int DEPTH = 64;
  logic sys_clk;
  logic reset_n;
  fifo_flag_pkg::pin_bus_s pins;
  fifo_flag_pkg::flags_s flags;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [8:0] data_out;
  logic upper_empty_n;
  logic upper_full_n;
  logic [31:0] rd;
  logic err;
  int num_errors;
  int num_checks;
  int cycles;
  int cnt;

  fifo_pin_partner partner (.sys_clk(sys_clk), .pins(pins));

  sync_fifo_flags #(.DEPTH(DEPTH)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .master_reset_n(pins.master_reset_n),
    .wr_clk(pins.wr_clk), .rd_clk(pins.rd_clk), .wr_en_primary_n(pins.wr_en_primary_n),
    .wr_en_second_or_load(pins.wr_en_second_or_load),
    .rd_en_primary_n(pins.rd_en_primary_n), .rd_en_second_n(pins.rd_en_second_n),
    .data_in(pins.data), .data_out(data_out), .empty_n(flags.empty_n),
    .full_n(flags.full_n), .almost_empty_n(flags.almost_empty_n),
    .almost_full_n(flags.almost_full_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Second device of a width-expanded pair; only its end-point flags are combined
  sync_fifo_flags #(.DEPTH(DEPTH)) upper_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .master_reset_n(pins.master_reset_n),
    .wr_clk(pins.wr_clk), .rd_clk(pins.rd_clk), .wr_en_primary_n(pins.wr_en_primary_n),
    .wr_en_second_or_load(pins.wr_en_second_or_load),
    .rd_en_primary_n(pins.rd_en_primary_n), .rd_en_second_n(pins.rd_en_second_n),
    .data_in(pins.data), .data_out(), .empty_n(upper_empty_n), .full_n(upper_full_n),
    .almost_empty_n(), .almost_full_n(), .psel(1'b0), .penable(1'b0), .pwrite(1'b0),
    .paddr(8'h00), .pwdata(32'h0), .prdata(), .pready(), .pslverr());

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the run watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Read-side flags follow the read clock, write-side flags the write clock
  task automatic chk_flags(input int n, input int m, input logic rd_side);
    if (rd_side) begin
      chk("empty_n", 32'(cnt > 0), 32'(flags.empty_n));
      chk("almost_empty_n", 32'(cnt > n), 32'(flags.almost_empty_n));
      chk("empty_all_n", 32'(cnt > 0), 32'(flags.empty_n & upper_empty_n));
    end else begin
      chk("full_n", 32'(cnt < DEPTH), 32'(flags.full_n));
      chk("almost_full_n", 32'(cnt < DEPTH - m), 32'(flags.almost_full_n));
      chk("full_all_n", 32'(cnt < DEPTH), 32'(flags.full_n & upper_full_n));
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_defaults();
    partner.dev_reset(1'b0);
    chk("flags", 32'(fifo_flag_pkg::FLAGS_RESET), 32'(flags));
    apb(1'b0, fifo_flag_pkg::REG_OFFSETS, 32'h0);
    chk("offsets", 32'h0007_0007, rd);
    apb(1'b0, fifo_flag_pkg::REG_STATUS, 32'h0);
    chk("load_mode", 32'h1, 32'(rd[fifo_flag_pkg::ST_LOAD_MODE_BIT]));
    apb(1'b1, fifo_flag_pkg::REG_STATUS, 32'h1);
    chk("status_wr_err", 32'h1, 32'(err));
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    apb(1'b1, fifo_flag_pkg::REG_OFFSETS, 32'h0009_0002);
    chk("offsets_wr_err", 32'h0, 32'(err));
    apb(1'b0, fifo_flag_pkg::REG_OFFSETS, 32'h0);
    chk("offsets_apb", 32'h0009_0002, rd);
  endtask

  task automatic test_load();
    logic [8:0] exp_b [4];
    exp_b = '{9'h003, 9'h000, 9'h005, 9'h000};
    partner.wr_cycle(1'b0, 1'b0, 9'h103);
    partner.wr_cycle(1'b0, 1'b0, 9'h000);
    partner.wr_cycle(1'b1, 1'b1, 9'h0FF);
    partner.wr_cycle(1'b0, 1'b0, 9'h005);
    partner.wr_cycle(1'b0, 1'b0, 9'h000);
    apb(1'b0, fifo_flag_pkg::REG_OFFSETS, 32'h0);
    chk("offsets", 32'h0005_0003, rd);
    foreach (exp_b[i]) begin
      partner.rd_cycle(1'b0, 1'b0, 1'b0);
      chk("offset_read", 32'(exp_b[i]), 32'(data_out));
    end
    chk("empty_n", 32'h0, 32'(flags.empty_n));
  endtask

  // Offsets n=3 and m=5 from the load scenario
  task automatic test_fill_drain();
    cnt = 0;
    for (int i = 0; i < DEPTH; i++) begin
      partner.wr_cycle(1'b0, 1'b1, 9'h100 | 9'(i));
      cnt++;
      chk_flags(3, 5, 1'b0);
      if (i == 0) chk("empty_held", 32'h0, 32'(flags.empty_n));
      partner.rd_cycle(1'b1, 1'b1, 1'b1);
      chk_flags(3, 5, 1'b1);
    end
    partner.wr_cycle(1'b0, 1'b1, 9'h0AA);
    partner.rd_cycle(1'b0, 1'b1, 1'b1);
    apb(1'b0, fifo_flag_pkg::REG_STATUS, 32'h0);
    chk("count", 32'(DEPTH), 32'(rd[fifo_flag_pkg::ST_COUNT_LSB +: 7]));
    for (int i = 0; i < DEPTH; i++) begin
      partner.rd_cycle(1'b0, 1'b0, 1'b1);
      cnt--;
      chk("word", 32'(9'h100 | 9'(i)), 32'(data_out));
      chk_flags(3, 5, 1'b1);
      if (i == 0) chk("full_held", 32'h0, 32'(flags.full_n));
      partner.wr_cycle(1'b1, 1'b1, 9'h0AA);
      chk_flags(3, 5, 1'b0);
    end
    partner.rd_cycle(1'b0, 1'b0, 1'b1);
    chk("underflow_word", 32'h13F, 32'(data_out));
  endtask

  task automatic test_second();
    partner.dev_reset(1'b1);
    apb(1'b0, fifo_flag_pkg::REG_STATUS, 32'h0);
    chk("load_mode", 32'h0, 32'(rd[fifo_flag_pkg::ST_LOAD_MODE_BIT]));
    partner.wr_cycle(1'b0, 1'b0, 9'h011);
    partner.rd_cycle(1'b1, 1'b1, 1'b1);
    chk("empty_n", 32'h0, 32'(flags.empty_n));
    apb(1'b0, fifo_flag_pkg::REG_OFFSETS, 32'h0);
    chk("offsets", 32'h0007_0007, rd);
    partner.wr_cycle(1'b0, 1'b1, 9'h022);
    partner.rd_cycle(1'b1, 1'b1, 1'b1);
    chk("empty_n", 32'h1, 32'(flags.empty_n));
  endtask

  task automatic test_done();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Whole run needs about 2500 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    test_defaults();
    test_load();
    test_fill_drain();
    test_second();
    test_done();
  end
endmodule
